// ==== design/phy_pin_logic.sv ====
`timescale 1ns/10ps
`default_nettype none

module phy_pin_logic (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // mii transmit side
  input  wire logic        tx_en_in,
  input  wire logic        tx_er_in,
  input  wire logic [3:0]  txd_in,
  // 10 Mb/s receive source and activity, collision at either speed
  input  wire logic [3:0]  rx10_data_in,
  input  wire logic        rx10_dv_in,
  input  wire logic        rx10_active_in,
  input  wire logic        collision_in,
  // mii receive outputs
  input  wire logic        rx_enable_in,
  output logic             rx_oe_out,
  output logic             rx_clk_out,
  output logic             rx_dv_out,
  output logic [3:0]       rxd_out,
  input  wire logic        rx_er_in,
  output logic             rx_er_out,
  output logic             rx_er_oe_out,
  // carrier and collision
  input  wire logic        crs_in,
  output logic             crs_out,
  output logic             crs_oe_out,
  output logic             col_out,
  // management
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_out,
  // transceiver side
  output logic             speed10_out,
  input  wire logic        line_code_select_in,
  output logic             line_code_select_out,
  output logic             line_code_select_oe_out,
  input  wire logic        transceiver_loopback_in,
  output logic             transceiver_loopback_out,
  output logic             transceiver_loopback_oe_out,
  output logic             td_out,
  input  wire logic        rd_in,
  input  wire logic        line_signal_present_in
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  phy_pin_pkg::ctrl_t     ctrl_r, ctrl_nxt;
  logic [4:0]             strap_r, strap_nxt;
  logic [3:0]             strap_cnt_r, strap_cnt_nxt;
  logic                   aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0]             aw_addr_r, aw_addr_nxt;
  logic [31:0]            w_data_r, w_data_nxt, rdata_nxt;
  logic                   bvalid_nxt, rvalid_nxt;
  logic [1:0]             bresp_nxt, rresp_nxt;
  logic [8:0]             acc_r, acc_nxt, step;
  logic                   rclk_r, rclk_nxt, fall_tick;
  phy_pin_pkg::rx_mii_t   hold_r, hold_nxt, rx_r, rx_nxt;
  logic                   hold_er4;
  logic [4:0]             rsh_r, rsh_nxt, tsh_r, tsh_nxt;
  logic [2:0]             rcnt_r, rcnt_nxt, tcnt_r, tcnt_nxt;
  logic                   inpkt_r, inpkt_nxt;
  logic                   tx_en_q_r;
  logic [7:0]             hb_cnt_r, hb_cnt_nxt;
  logic                   mdc_q_r, mdc_rise;
  phy_pin_pkg::md_state_t md_st_r, md_st_nxt;
  logic [5:0]             ones_r, ones_nxt;
  logic [3:0]             bcnt_r, bcnt_nxt;
  logic [12:0]            hdr_r, hdr_nxt;
  logic [15:0]            mdat_r, mdat_nxt;
  logic                   mrd_r, mrd_nxt, mdo_r, mdo_nxt, mdoe_r, mdoe_nxt;
  logic                   md_wr;
  logic                   bypass, half, crs_int, col_int, strap_done;
  logic [4:0]             dec, rsym;

  assign bypass     = ctrl_r.codec_byp | ctrl_r.align_byp;
  assign half       = ~ctrl_r.full_dup;
  assign strap_done = (strap_cnt_r == phy_pin_pkg::STRAP_CYC);
  assign mdc_rise   = mdc_in & ~mdc_q_r;

  // ---------------------------------------------------------------
  // register bus and control
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready  = ~w_held_r;
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    aw_held_nxt = aw_held_r | s_axi_awvalid;
    aw_addr_nxt = (s_axi_awvalid & ~aw_held_r) ? s_axi_awaddr : aw_addr_r;
    w_held_nxt  = w_held_r | s_axi_wvalid;
    w_data_nxt  = (s_axi_wvalid & ~w_held_r) ? s_axi_wdata : w_data_r;
    bvalid_nxt  = s_axi_bvalid & ~s_axi_bready;
    bresp_nxt   = s_axi_bresp;
    ctrl_nxt    = ctrl_r;
    // management write to control word
    if (md_wr) begin
      ctrl_nxt = phy_pin_pkg::ctrl_t'({mdat_r[8:0], mdio_in});
    end
    if (aw_held_r & w_held_r & ~s_axi_bvalid) begin
      aw_held_nxt = 1'h0;
      w_held_nxt  = 1'h0;
      bvalid_nxt  = 1'h1;
      bresp_nxt   = phy_pin_pkg::RESP_SLV;
      if (aw_addr_r == phy_pin_pkg::CTRL_OFF) begin
        bresp_nxt = phy_pin_pkg::RESP_OKAY;
        if (s_axi_wstrb[0]) begin
          ctrl_nxt[7:0] = w_data_r[7:0];
        end
        if (s_axi_wstrb[1]) begin
          ctrl_nxt[9:8] = w_data_r[9:8];
        end
      end else if (aw_addr_r == phy_pin_pkg::STAT_OFF) begin
        bresp_nxt = phy_pin_pkg::RESP_OKAY;
      end
    end
    rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (s_axi_arvalid & ~s_axi_rvalid) begin
      rvalid_nxt = 1'h1;
      rresp_nxt  = phy_pin_pkg::RESP_OKAY;
      if (s_axi_araddr == phy_pin_pkg::CTRL_OFF) begin
        rdata_nxt = {22'h000000, ctrl_r};
      end else if (s_axi_araddr == phy_pin_pkg::STAT_OFF) begin
        rdata_nxt = {21'h000000, strap_done, line_signal_present_in, inpkt_r,
                     col_int, crs_int, 1'h0, strap_r};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = phy_pin_pkg::RESP_SLV;
      end
    end
    strap_cnt_nxt = strap_done ? strap_cnt_r : strap_cnt_r + 4'h1;
    strap_nxt     = strap_r;
    // sense address straps while pins are released
    if (strap_cnt_r == phy_pin_pkg::STRAP_CYC - 4'h1) begin
      strap_nxt = {rx_er_in, phy_pin_pkg::STRAP_BIT3, crs_in, line_code_select_in,
                   transceiver_loopback_in};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r       <= phy_pin_pkg::CTRL_RESET;
      aw_held_r    <= 1'h0;
      aw_addr_r    <= 8'h00;
      w_held_r     <= 1'h0;
      w_data_r     <= 32'h00000000;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
      strap_cnt_r  <= 4'h0;
      strap_r      <= 5'h00;
    end else begin
      ctrl_r       <= ctrl_nxt;
      aw_held_r    <= aw_held_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_held_r     <= w_held_nxt;
      w_data_r     <= w_data_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp  <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata  <= rdata_nxt;
      s_axi_rresp  <= rresp_nxt;
      strap_cnt_r  <= strap_cnt_nxt;
      strap_r      <= strap_nxt;
    end
  end

  // ---------------------------------------------------------------
  // management frames
  // ---------------------------------------------------------------
  always_comb begin
    md_st_nxt = md_st_r;
    ones_nxt  = ones_r;
    bcnt_nxt  = bcnt_r;
    hdr_nxt   = hdr_r;
    mdat_nxt  = mdat_r;
    mrd_nxt   = mrd_r;
    mdo_nxt   = mdo_r;
    mdoe_nxt  = mdoe_r;
    md_wr     = 1'h0;
    if (mdc_rise) begin
      case (md_st_r)
        phy_pin_pkg::MD_PRE: begin
          if (mdio_in) begin
            ones_nxt = (ones_r == phy_pin_pkg::PRE_LEN) ? ones_r : ones_r + 6'h01;
          end else begin
            ones_nxt = 6'h00;
            bcnt_nxt = 4'h0;
            if (ones_r == phy_pin_pkg::PRE_LEN) begin
              md_st_nxt = phy_pin_pkg::MD_HDR;
            end
          end
        end
        phy_pin_pkg::MD_HDR: begin
          hdr_nxt  = {hdr_r[11:0], mdio_in};
          bcnt_nxt = bcnt_r + 4'h1;
          if (bcnt_r == phy_pin_pkg::HDR_LAST) begin
            bcnt_nxt  = 4'h0;
            md_st_nxt = phy_pin_pkg::MD_PRE;
            mrd_nxt   = (hdr_nxt[11:10] == phy_pin_pkg::OP_RD);
            mdat_nxt  = (hdr_nxt[4:0] == phy_pin_pkg::CTRL_MDREG) ?
                        {6'h00, ctrl_r} : 16'h0000;
            if (hdr_nxt[12] && hdr_nxt[9:5] == strap_r &&
                (mrd_nxt || hdr_nxt[11:10] == phy_pin_pkg::OP_WR)) begin
              md_st_nxt = phy_pin_pkg::MD_TA;
            end
          end
        end
        phy_pin_pkg::MD_TA: begin
          bcnt_nxt = bcnt_r + 4'h1;
          // drive only on read turnaround and data
          if (bcnt_r == 4'h0) begin
            mdoe_nxt = mrd_r;
            mdo_nxt  = 1'h0;
          end else begin
            bcnt_nxt  = 4'h0;
            md_st_nxt = phy_pin_pkg::MD_DATA;
            mdo_nxt   = mdat_r[15];
            mdat_nxt  = {mdat_r[14:0], 1'h0};
          end
        end
        phy_pin_pkg::MD_DATA: begin
          bcnt_nxt = bcnt_r + 4'h1;
          mdo_nxt  = mdat_r[15];
          mdat_nxt = mrd_r ? {mdat_r[14:0], 1'h0} : {mdat_r[14:0], mdio_in};
          if (bcnt_r == phy_pin_pkg::DAT_LAST) begin
            md_wr     = ~mrd_r;
            mdoe_nxt  = 1'h0;
            md_st_nxt = phy_pin_pkg::MD_PRE;
          end
        end
        default: begin
          md_st_nxt = phy_pin_pkg::MD_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mdc_q_r <= 1'h0;
      md_st_r <= phy_pin_pkg::MD_PRE;
      ones_r  <= 6'h00;
      bcnt_r  <= 4'h0;
      hdr_r   <= 13'h0000;
      mdat_r  <= 16'h0000;
      mrd_r   <= 1'h0;
      mdo_r   <= 1'h0;
      mdoe_r  <= 1'h0;
    end else begin
      mdc_q_r <= mdc_in;
      md_st_r <= md_st_nxt;
      ones_r  <= ones_nxt;
      bcnt_r  <= bcnt_nxt;
      hdr_r   <= hdr_nxt;
      mdat_r  <= mdat_nxt;
      mrd_r   <= mrd_nxt;
      mdo_r   <= mdo_nxt;
      mdoe_r  <= mdoe_nxt;
    end
  end

  assign mdio_out    = mdo_r;
  assign mdio_oe_out = mdoe_r;

  // ---------------------------------------------------------------
  // serial line and receive path
  // ---------------------------------------------------------------
  assign rsym     = {rsh_r[3:0], rd_in};
  assign dec      = phy_pin_pkg::dec_sym(rsym);
  // fifth raw bit rides on error
  assign hold_er4 = bypass & rsym[4];

  always_comb begin
    // one code bit per cycle each way
    rsh_nxt   = rsym;
    rcnt_nxt  = (rcnt_r == phy_pin_pkg::SYM_LAST) ? 3'h0 : rcnt_r + 3'h1;
    tcnt_nxt  = (tcnt_r == phy_pin_pkg::SYM_LAST) ? 3'h0 : tcnt_r + 3'h1;
    tsh_nxt   = {tsh_r[3:0], 1'h0};
    inpkt_nxt = inpkt_r;
    hold_nxt  = hold_r;
    if (tcnt_r == phy_pin_pkg::SYM_LAST) begin
      tsh_nxt = phy_pin_pkg::SYM_IDLE;
      if (bypass) begin
        tsh_nxt = {tx_er_in, txd_in};
      end else if (tx_en_in & tx_er_in) begin
        tsh_nxt = phy_pin_pkg::SYM_HALT;
      end else if (tx_en_in) begin
        tsh_nxt = phy_pin_pkg::enc_sym(txd_in);
      end
    end
    if (!line_signal_present_in) begin
      inpkt_nxt = 1'h0;
    end else if (!inpkt_r && rsym == phy_pin_pkg::SYM_J && !ctrl_r.align_byp) begin
      inpkt_nxt = 1'h1;
      rcnt_nxt  = 3'h0;
    end else if (rcnt_r == phy_pin_pkg::SYM_LAST && inpkt_r &&
                 (rsym == phy_pin_pkg::SYM_T || rsym == phy_pin_pkg::SYM_IDLE)) begin
      inpkt_nxt = 1'h0;
    end
    if (ctrl_r.speed10) begin
      hold_nxt = '{dv: rx10_dv_in, er: 1'h0, rxd: rx10_data_in};
      if (ctrl_r.serial10) begin
        hold_nxt.rxd = {3'h0, rx10_data_in[0]};
      end
    end else if (ctrl_r.align_byp) begin
      if (rcnt_r == phy_pin_pkg::SYM_LAST) begin
        hold_nxt = '{dv: line_signal_present_in, er: hold_er4, rxd: rsym[3:0]};
      end
    end else if (rcnt_r == phy_pin_pkg::SYM_LAST) begin
      hold_nxt = '{dv: inpkt_nxt, er: inpkt_nxt & ~dec[4], rxd: dec[3:0]};
      if (ctrl_r.codec_byp) begin
        hold_nxt = '{dv: inpkt_nxt, er: hold_er4, rxd: rsym[3:0]};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsh_r   <= 5'h00;
      rcnt_r  <= 3'h0;
      tcnt_r  <= 3'h0;
      tsh_r   <= phy_pin_pkg::SYM_IDLE;
      inpkt_r <= 1'h0;
      hold_r  <= '0;
    end else begin
      rsh_r   <= rsh_nxt;
      rcnt_r  <= rcnt_nxt;
      tcnt_r  <= tcnt_nxt;
      tsh_r   <= tsh_nxt;
      inpkt_r <= inpkt_nxt;
      hold_r  <= hold_nxt;
    end
  end

  assign td_out = tsh_r[4];

  // ---------------------------------------------------------------
  // receive clock and mii outputs
  // ---------------------------------------------------------------
  always_comb begin
    step = ctrl_r.speed10 ? (ctrl_r.serial10 ? phy_pin_pkg::STEP_10S :
                             phy_pin_pkg::STEP_10N) : phy_pin_pkg::STEP_100N;
    acc_nxt   = acc_r + step;
    fall_tick = 1'h0;
    rclk_nxt  = rclk_r;
    rx_nxt    = rx_r;
    if (acc_nxt >= phy_pin_pkg::ACC_MOD_V) begin
      acc_nxt   = acc_nxt - phy_pin_pkg::ACC_MOD_V;
      rclk_nxt  = ~rclk_r;
      fall_tick = rclk_r;
    end
    if (fall_tick) begin
      rx_nxt = hold_r;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_r  <= 9'h000;
      rclk_r <= 1'h0;
      rx_r   <= '0;
    end else begin
      acc_r  <= acc_nxt;
      rclk_r <= rclk_nxt;
      rx_r   <= rx_nxt;
    end
  end

  assign rx_clk_out   = rclk_r;
  assign rx_dv_out    = rx_r.dv;
  assign rxd_out      = rx_r.rxd;
  assign rx_er_out    = rx_r.er;
  assign rx_oe_out    = rx_enable_in;
  assign rx_er_oe_out = rx_enable_in & strap_done;

  // ---------------------------------------------------------------
  // carrier, collision, heartbeat
  // ---------------------------------------------------------------
  always_comb begin
    hb_cnt_nxt = (hb_cnt_r == 8'h00) ? 8'h00 : hb_cnt_r - 8'h01;
    if (tx_en_q_r && !tx_en_in && ctrl_r.speed10 && half && ctrl_r.heartbeat) begin
      hb_cnt_nxt = 8'(phy_pin_pkg::HB_CYC);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_en_q_r <= 1'h0;
      hb_cnt_r  <= 8'h00;
    end else begin
      tx_en_q_r <= tx_en_in;
      hb_cnt_r  <= hb_cnt_nxt;
    end
  end

  assign crs_int = (ctrl_r.speed10 ? rx10_active_in : inpkt_r) |
                   (tx_en_in & half & ~ctrl_r.repeater & ~ctrl_r.loopback);
  assign col_int = half & (collision_in | (hb_cnt_r != 8'h00));

  assign crs_out    = crs_int;
  assign crs_oe_out = strap_done;
  assign col_out    = col_int;

  // ---------------------------------------------------------------
  // transceiver controls
  // ---------------------------------------------------------------
  // speed indication
  assign speed10_out                 = ctrl_r.speed10;
  assign line_code_select_out        = ctrl_r.line_code;
  assign line_code_select_oe_out     = strap_done;
  assign transceiver_loopback_out    = ctrl_r.xcvr_lb;
  assign transceiver_loopback_oe_out = strap_done;

endmodule

`default_nettype wire

// ==== design/phy_pin_pkg.sv ====
`default_nettype none

package phy_pin_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ       = 125000;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int HB_TIME_NS    = 1000;
  localparam int HB_CYC        = (HB_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int RATE_100N_KHZ = 25000;
  localparam int RATE_10N_KHZ  = 2500;
  localparam int RATE_10S_KHZ  = 10000;
  localparam int ACC_MOD       = 250;
  localparam int ACC_DIV       = CLK_KHZ / ACC_MOD;
  localparam logic [8:0] STEP_100N = 9'((2 * RATE_100N_KHZ) / ACC_DIV);
  localparam logic [8:0] STEP_10N  = 9'((2 * RATE_10N_KHZ) / ACC_DIV);
  localparam logic [8:0] STEP_10S  = 9'((2 * RATE_10S_KHZ) / ACC_DIV);
  localparam logic [8:0] ACC_MOD_V = 9'(ACC_MOD);
  localparam logic [2:0] SYM_LAST  = 3'h4;
  localparam logic [3:0] STRAP_CYC = 4'h8;
  localparam logic       STRAP_BIT3 = 1'h0;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFF   = 8'h00;
  localparam logic [7:0]  STAT_OFF   = 8'h04;
  localparam logic [4:0]  CTRL_MDREG = 5'h1C;
  localparam logic [9:0]  CTRL_RESET = 10'h000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  // ---------------------------------------------------------------
  // management frame
  // ---------------------------------------------------------------
  localparam logic [5:0] PRE_LEN  = 6'h20;
  localparam logic [3:0] HDR_LAST = 4'hC;
  localparam logic [3:0] DAT_LAST = 4'hF;
  localparam logic [1:0] OP_RD    = 2'h2;
  localparam logic [1:0] OP_WR    = 2'h1;

  // ---------------------------------------------------------------
  // line symbols
  // ---------------------------------------------------------------
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [4:0] SYM_J    = 5'h18;
  localparam logic [4:0] SYM_T    = 5'h0D;
  localparam logic [4:0] SYM_HALT = 5'h04;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic xcvr_lb;
    logic line_code;
    logic align_byp;
    logic codec_byp;
    logic serial10;
    logic heartbeat;
    logic loopback;
    logic repeater;
    logic full_dup;
    logic speed10;
  } ctrl_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] rxd;
  } rx_mii_t;

  typedef enum logic [2:0] {
    MD_PRE  = 3'h0,
    MD_HDR  = 3'h1,
    MD_TA   = 3'h2,
    MD_DATA = 3'h3
  } md_state_t;

  function automatic logic [4:0] enc_sym(input logic [3:0] nib);
    case (nib)
      4'h0: enc_sym = 5'h1E;
      4'h1: enc_sym = 5'h09;
      4'h2: enc_sym = 5'h14;
      4'h3: enc_sym = 5'h15;
      4'h4: enc_sym = 5'h0A;
      4'h5: enc_sym = 5'h0B;
      4'h6: enc_sym = 5'h0E;
      4'h7: enc_sym = 5'h0F;
      4'h8: enc_sym = 5'h12;
      4'h9: enc_sym = 5'h13;
      4'hA: enc_sym = 5'h16;
      4'hB: enc_sym = 5'h17;
      4'hC: enc_sym = 5'h1A;
      4'hD: enc_sym = 5'h1B;
      4'hE: enc_sym = 5'h1C;
      default: enc_sym = 5'h1D;
    endcase
  endfunction

  // returns {valid, nibble}
  function automatic logic [4:0] dec_sym(input logic [4:0] sym);
    dec_sym = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc_sym(4'(i)) == sym) begin
        dec_sym = {1'h1, 4'(i)};
      end
    end
  endfunction

endpackage

`default_nettype wire

// ==== verif/mgmt_station_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mgmt_station_model (
  input  wire logic clk_in, mdio_out, mdio_oe_out,
  output var logic  mdc_in,
  output wire logic mdio_in
);
  logic sm_oe = 1'h0;
  logic sm_d  = 1'h1;
  // released line floats to the pull-up level
  assign mdio_in = mdio_oe_out ? mdio_out : (sm_oe ? sm_d : 1'h1);
  initial mdc_in = 1'h0;
  // one management frame, clock at 2.5 MHz
  task automatic frame(input logic [31:0] hdr, output logic [15:0] rd);
    for (int i = 63; i >= 0; i--) begin
      sm_oe <= !(hdr[29] && i < 18);
      sm_d <= (i > 31) | hdr[i % 32];
      repeat (25) @(posedge clk_in);
      if (i < 16) rd[i] = mdio_in;
      mdc_in <= 1'h1;
      repeat (25) @(posedge clk_in);
      mdc_in <= 1'h0;
    end
    sm_oe <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== verif/phy_pin_logic_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module phy_pin_logic_props (
  // watched ports
  input wire logic       clk_in, rst_n_in, rx_enable_in, rx_oe_out, rx_clk_out, rx_dv_out,
  input wire logic [3:0] rxd_out,
  input wire logic       rx_er_out, rx_er_oe_out, crs_oe_out, mdio_out, mdio_oe_out,
  input wire logic       line_code_select_oe_out, transceiver_loopback_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rx_float:
    assert property (rx_oe_out == rx_enable_in) else $error("rx enable");
  a_er_float:
    assert property (rx_er_oe_out == (rx_enable_in && crs_oe_out)) else $error("er enable");
  a_strap_oe:
    assert property (line_code_select_oe_out == crs_oe_out
      && transceiver_loopback_oe_out == crs_oe_out) else $error("strap enable");
  a_strap_wait:
    assert property ($rose(rst_n_in) |-> !crs_oe_out [*7] ##[1:3] crs_oe_out) else $error("strap");
  a_rxd_on_fall:
    assert property (!$stable({rx_dv_out, rx_er_out, rxd_out}) |-> $fell(rx_clk_out))
      else $error("rx data edge");
  a_rxclk_min:
    assert property ($changed(rx_clk_out) |=> $stable(rx_clk_out)) else $error("rx clk fast");
  a_rxclk_max:
    assert property ($changed(rx_clk_out) |-> ##[1:26] $changed(rx_clk_out)) else $error("slow");
  a_mdio_turn:
    assert property ($rose(mdio_oe_out) |-> !mdio_out ##1 mdio_oe_out [*8]) else $error("mdio");
endmodule
bind phy_pin_logic phy_pin_logic_props phy_pin_logic_props_i (.*);
`default_nettype wire

// ==== verif/phy_pin_logic_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module phy_pin_logic_tb;
  localparam logic [4:0] ADDR = 5'h15;
  logic clk_in = 1'h0, rst_n_in = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, p;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tx_en_in = 1'h0;
  logic tx_er_in = 1'h0, rx10_active_in = 1'h0, collision_in = 1'h0, rx_enable_in = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0] txd_in = 4'h0, rxd_out, rx10_data_in = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic rx10_dv_in = 1'h0, line_signal_present_in = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_oe_out;
  logic rx_clk_out, rx_dv_out, rx_er_out, rx_er_oe_out, crs_out, crs_oe_out, col_out, td_out;
  logic mdio_out, mdio_oe_out, speed10_out, line_code_select_out, line_code_select_oe_out;
  logic transceiver_loopback_out, transceiver_loopback_oe_out;
  logic [15:0] md;
  logic [9:0] v;
  wire logic mdc_in, mdio_in;
  wire logic crs_in = crs_oe_out ? crs_out : 1'h1;
  wire logic line_code_select_in = line_code_select_oe_out ? line_code_select_out : 1'h0;
  wire logic transceiver_loopback_in = transceiver_loopback_oe_out ? transceiver_loopback_out : 1'h1;
  wire logic rx_er_in = rx_er_oe_out ? rx_er_out : 1'h1;
  int error_cnt = 0, n_checks = 0, cyc = 0, n;
  int rate[3] = '{phy_pin_pkg::RATE_100N_KHZ, phy_pin_pkg::RATE_10N_KHZ, phy_pin_pkg::RATE_10S_KHZ};
  int hbn[2] = '{1000 / 8, 0};
  logic [31:0] modes[3] = '{32'h0, 32'h1, 32'h21};
  logic [31:0] hbm[2] = '{32'h11, 32'h13};
  always #4 clk_in = ~clk_in;
  // serial code bits looped back from transmit to receive
  phy_pin_logic phy_pin_logic_i (.*, .s_axi_wstrb(4'hF), .rd_in(td_out));
  mgmt_station_model mgmt_station_model_i (.*);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic int near(int c, int e);
    return (c >= e - 2 && c <= e + 2) ? e : c;
  endfunction
  task automatic axw(input logic [31:0] d);
    @(posedge clk_in);
    s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
    s_axi_awaddr <= phy_pin_pkg::CTRL_OFF; s_axi_wdata <= d;
    fork
      begin @(posedge clk_in iff s_axi_awready); s_axi_awvalid <= 1'h0; end
      begin @(posedge clk_in iff s_axi_wready); s_axi_wvalid <= 1'h0; end
      begin @(posedge clk_in iff s_axi_bvalid); s_axi_bready <= 1'h0; r = s_axi_bresp; end
    join
    chk("bresp", 32'h0, r);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_arvalid <= 1'h1; s_axi_araddr <= a; s_axi_rready <= 1'h1;
    fork
      begin @(posedge clk_in iff s_axi_arready); s_axi_arvalid <= 1'h0; end
      begin @(posedge clk_in iff s_axi_rvalid); s_axi_rready <= 1'h0; r = s_axi_rdata; rr = s_axi_rresp; end
    join
    chk("rdata", e, r);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask
  task automatic sym(input int e);
    repeat (20) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin @(posedge clk_in); v[i] = td_out; end
    chk("td", e, (v[9:5] === v[4:0]) ? $countones(v[4:0]) : 99);
  endtask
  task automatic cc(input logic [31:0] d, input logic [1:0] e);
    axw(d);
    repeat (12) @(posedge clk_in);
    chk("col crs", {30'h0, e}, {30'h0, col_out, crs_out});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin error_cnt++; tally_and_finish(); end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'h1;
    repeat (12) @(posedge clk_in);
    axr(phy_pin_pkg::STAT_OFF, {21'h0, 1'h1, 5'h0, ADDR}, phy_pin_pkg::RESP_OKAY);
    axr(8'h0C, 32'h0, phy_pin_pkg::RESP_SLV);
    mgmt_station_model_i.frame({4'h5, ADDR, phy_pin_pkg::CTRL_MDREG, 18'h20301}, md);
    chk("pins", 32'h7, {29'h0, speed10_out, line_code_select_out, transceiver_loopback_out});
    axr(phy_pin_pkg::CTRL_OFF, 32'h301, phy_pin_pkg::RESP_OKAY);
    mgmt_station_model_i.frame({4'h6, ADDR ^ 5'h01, phy_pin_pkg::CTRL_MDREG, 18'h3FFFF}, md);
    chk("foreign", 32'hFFFF, {16'h0, md});
    mgmt_station_model_i.frame({4'h6, ADDR, phy_pin_pkg::CTRL_MDREG, 18'h3FFFF}, md);
    chk("mgmt read", 32'h301, {16'h0, md});
    for (int k = 0; k < 3; k++) begin
      axw(modes[k]);
      repeat (60) @(posedge clk_in);
      n = 0;
      p = rx_clk_out;
      repeat (1000) begin @(posedge clk_in); n += int'(rx_clk_out && !p); p = rx_clk_out; end
      chk("rx clk", rate[k] / 125, near(n, rate[k] / 125));
    end
    rx10_data_in <= 4'hF; rx10_dv_in <= 1'h1;
    repeat (40) @(posedge clk_in);
    chk("rx serial", 32'h11, {27'h0, rx_dv_out, rxd_out});
    axw(32'h0);
    tx_en_in <= 1'h1; tx_er_in <= 1'h1; txd_in <= 4'hE;
    sym($countones(phy_pin_pkg::SYM_HALT));
    axw(32'h40);
    sym(4);
    txd_in <= 4'h8; line_signal_present_in <= 1'h1;
    repeat (40) @(posedge clk_in);
    chk("rx raw", 32'h38, {26'h0, rx_dv_out, rx_er_out, rxd_out});
    axw(32'h0);
    repeat (40) @(posedge clk_in);
    chk("rx halt", 32'h30, {26'h0, rx_dv_out, rx_er_out, rxd_out});
    line_signal_present_in <= 1'h0;
    repeat (40) @(posedge clk_in);
    chk("rx end", 32'h0, {26'h0, rx_dv_out, rx_er_out, rxd_out});
    tx_er_in <= 1'h0; collision_in <= 1'h1;
    cc(32'h0, 2'h3);
    cc(32'h4, 2'h2);
    cc(32'h8, 2'h2);
    cc(32'h2, 2'h0);
    rx10_active_in <= 1'h1;
    cc(32'h3, 2'h1);
    collision_in <= 1'h0; rx10_active_in <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      axw(hbm[k]);
      tx_en_in <= 1'h1;
      repeat (20) @(posedge clk_in);
      tx_en_in <= 1'h0;
      n = 0;
      repeat (400) begin @(posedge clk_in); n += int'(col_out); end
      chk("heartbeat", hbn[k], near(n, hbn[k]));
    end
    rx_enable_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    chk("rx oe", 32'h0, {31'h0, rx_oe_out});
    tally_and_finish();
  end
endmodule
`default_nettype wire
